// [core/cims_device.sv]
/*
  codec start-up and shut-down sequencer, device end.
  assumes the link pins come from another domain; ref_clk at 125 MHz, master clock at most a quarter of it.
*/
// Functional notes
// RL1: host sends zero audio ten frames before change
// RL2: clock change forces converter data zero
// RL3: mute outputs low in reset, ramp, mute, pdn
// RL4: mute output push-pull, active low
// RL5: power-on enters power-down, all reset
// RL6: power-down held while chip reset low
// RL7: serial output high at release: hardware mode
// RL8: serial output low at release: software standby
// RL9: hardware mode waits master clock only
// RL10: reference ramp mutes serial and analog outputs
// RL11: count master clocks per frame, then run
// RL12: software power-up on power-down bit clear
// RL13: host orders reset, registers, clocks, pdn, audio
// RL14: pdn set: power down after full mute
// RL15: host mutes streams before hardware reset
// RL16: host resets on supply fault; host only reports the fault flag, chip reset follows the release bit
// RL17: hardware mode powers converters, fault flag
// RL18: hardware straps set role, divide, format, mute
// RL19: hardware ADC defaults fixed
// RL20: hardware DAC and output defaults fixed
// RL21: DAC audio after two hundred frames
// RL22: mode latched until next chip reset
`timescale 1ns/1ps
`include "cims_consts.svh"
module cims_device #(
  parameter int RAMP_CYCLES = `CIMS_RAMP_CYCLES,
  parameter int MUTE_CYCLES = `CIMS_MUTE_CYCLES,
  parameter int DAC_FRAMES = `CIMS_DAC_START_FRAMES
) (
  input wire logic ref_clk,
  input wire logic arst_n,
  cims_link_if.device link,
  input wire logic adcBit,
  output logic dacData,
  output logic dacEnable,
  output logic hwMode,
  output logic modeValid,
  output logic [11:0] clockRatio,
  output logic ratioFault,
  output cims_pkg::cims_state_t seqState,
  output cims_pkg::cims_cfg_t hwConfig
);

  typedef struct packed {
    cims_pkg::cims_state_t state;
    logic [1:0] rstSync;
    logic rstPrev;
    logic [1:0] sdoSync;
    logic [1:0] mckSync;
    logic mckPrev;
    logic [1:0] frmSync;
    logic frmPrev;
    logic frmArmed;
    logic [1:0] sdinSync;
    logic [1:0] pdnSync;
    logic [1:0] muteSync;
    logic [4:0] strapS1;
    logic [4:0] strapS2;
    logic hwMode;
    logic modeValid;
    logic [24:0] timer;
    logic [11:0] mclkCnt;
    logic [11:0] ratio;
    logic [7:0] frameCnt;
    logic dacEnable;
    logic ratioFault;
    logic dacData;
    logic muteN;
    logic sdoOut;
    logic sdoOe;
    cims_pkg::cims_cfg_t cfg;
  } cims_dev_t;

  cims_dev_t s_q;
  cims_dev_t s_d;

  function automatic logic isHwRatio(input logic [11:0] r);
    isHwRatio = (r == `CIMS_RATIO_128) || (r == `CIMS_RATIO_256) || (r == `CIMS_RATIO_512);
  endfunction

  logic chipUp;
  logic mckRise;
  logic frmRise;
  logic pdnSet;

  assign chipUp = s_q.rstSync[1];
  assign mckRise = s_q.mckSync[1] && !s_q.mckPrev;
  assign frmRise = s_q.frmSync[1] && !s_q.frmPrev;
  assign pdnSet = !s_q.hwMode && s_q.pdnSync[1];

  always_comb begin
    s_d = s_q;
    s_d.rstSync = {s_q.rstSync[0], link.chipReset_n};
    s_d.sdoSync = {s_q.sdoSync[0], link.serialAudioOutput};
    s_d.mckSync = {s_q.mckSync[0], link.masterClockOne};
    s_d.frmSync = {s_q.frmSync[0], link.frameClock};
    s_d.sdinSync = {s_q.sdinSync[0], link.serialAudioInput};
    s_d.pdnSync = {s_q.pdnSync[0], link.powerDownBit};
    s_d.muteSync = {s_q.muteSync[0], link.softMute};
    s_d.strapS1 = link.straps;
    s_d.strapS2 = s_q.strapS1;
    s_d.rstPrev = chipUp;
    s_d.mckPrev = s_q.mckSync[1];
    s_d.frmPrev = s_q.frmSync[1];
    if (mckRise) begin
      s_d.mclkCnt = s_q.mclkCnt + 12'h001;
    end
    case (s_q.state)
      cims_pkg::ST_POWERDOWN: begin
        if (chipUp && !s_q.rstPrev) begin
          s_d.modeValid = 1'b1; // RL22
          if (s_q.sdoSync[1]) begin
            s_d.hwMode = 1'b1; // RL7
            s_d.state = cims_pkg::ST_WAIT_MCLK; // RL7
          end else begin
            s_d.hwMode = 1'b0; // RL8
            s_d.state = cims_pkg::ST_STANDBY; // RL8
          end
        end
      end
      cims_pkg::ST_STANDBY: begin
        if (!s_q.pdnSync[1]) begin
          s_d.state = cims_pkg::ST_WAIT_MCLK; // RL12
        end
      end
      cims_pkg::ST_WAIT_MCLK: begin
        s_d.timer = '0;
        if (mckRise) begin
          s_d.state = cims_pkg::ST_RAMP; // RL9
        end
      end
      cims_pkg::ST_RAMP: begin
        s_d.timer = s_q.timer + 25'h0000001;
        if (s_q.timer >= 25'(RAMP_CYCLES - 1)) begin
          s_d.state = cims_pkg::ST_DETECT;
          s_d.frmArmed = 1'b0;
        end
      end
      cims_pkg::ST_DETECT: begin
        if (frmRise) begin
          // a master rise on the frame edge opens the new count
          s_d.mclkCnt = {11'h000, mckRise}; // RL11
          s_d.frmArmed = 1'b1;
          if (s_q.frmArmed) begin
            s_d.ratio = s_q.mclkCnt; // RL11
            s_d.ratioFault = s_q.hwMode && !isHwRatio(s_q.mclkCnt); // RL17
            s_d.frameCnt = '0;
            s_d.state = cims_pkg::ST_RUN; // RL11
          end
        end
      end
      cims_pkg::ST_RUN: begin
        if (frmRise) begin
          s_d.mclkCnt = {11'h000, mckRise}; // RL11
          if (s_q.mclkCnt != s_q.ratio) begin
            s_d.dacEnable = 1'b0; // RL2
            s_d.frmArmed = 1'b1;
            s_d.state = cims_pkg::ST_DETECT; // RL2
          end else if (s_q.frameCnt >= 8'(DAC_FRAMES - 1)) begin
            s_d.dacEnable = 1'b1; // RL21
          end else begin
            s_d.frameCnt = s_q.frameCnt + 8'h01; // RL21
          end
        end
      end
      cims_pkg::ST_MUTING: begin
        s_d.timer = s_q.timer + 25'h0000001;
        if (s_q.timer >= 25'(MUTE_CYCLES - 1)) begin
          s_d.state = cims_pkg::ST_STANDBY; // RL14
        end
      end
      default: begin
        s_d.state = cims_pkg::ST_POWERDOWN;
      end
    endcase
    if (pdnSet && (s_q.state == cims_pkg::ST_RAMP || s_q.state == cims_pkg::ST_DETECT
        || s_q.state == cims_pkg::ST_RUN || s_q.state == cims_pkg::ST_WAIT_MCLK)) begin
      s_d.state = cims_pkg::ST_MUTING; // RL14
      s_d.timer = '0;
      s_d.dacEnable = 1'b0;
    end
    if (!chipUp) begin
      s_d.state = cims_pkg::ST_POWERDOWN; // RL6
      s_d.modeValid = 1'b0; // RL22
      s_d.hwMode = 1'b0;
      s_d.dacEnable = 1'b0;
      s_d.ratioFault = 1'b0;
      s_d.frameCnt = '0;
    end
    // zero data unless fully running
    s_d.dacData = (s_d.state == cims_pkg::ST_RUN) && s_d.dacEnable && s_q.sdinSync[1]; // RL2
    s_d.muteN = (s_d.state == cims_pkg::ST_RUN) && s_d.dacEnable && !s_q.muteSync[1] && !pdnSet
                && !(s_d.hwMode && s_q.strapS2[4]); // RL3
    // serial output driven low while ramping or not running, released in standby and before the mode latches
    s_d.sdoOe = s_d.modeValid && (s_d.state != cims_pkg::ST_STANDBY); // RL10
    s_d.sdoOut = (s_d.state == cims_pkg::ST_RUN) && s_d.dacEnable && adcBit; // RL10
    s_d.cfg = '0;
    if (s_d.hwMode) begin
      s_d.cfg.adcPwr = 1'b1; // RL17
      s_d.cfg.dac1Pwr = 1'b1; // RL17
      s_d.cfg.dac2Pwr = 1'b1; // RL17
      s_d.cfg.faultEn = 1'b1; // RL17
      s_d.cfg.autoDetect = 1'b1; // RL17
      s_d.cfg.syncOnly = 1'b1; // RL17
      s_d.cfg.roleLo = s_q.strapS2[0]; // RL18
      s_d.cfg.roleHi = s_q.strapS2[1]; // RL18
      s_d.cfg.clkDiv = s_q.strapS2[2]; // RL18
      s_d.cfg.formatSp1 = s_q.strapS2[3]; // RL18
      s_d.cfg.formatSp2 = s_q.strapS2[3]; // RL18
      s_d.cfg.outMute = s_q.strapS2[4]; // RL18
      s_d.cfg.adcSoft = 1'b1; // RL19
      s_d.cfg.adcVol = `CIMS_VOL_0DB; // RL19
      s_d.cfg.hpfOn = 1'b1; // RL19
      s_d.cfg.hpfFreeze = 1'b0; // RL19
      s_d.cfg.ainSel = `CIMS_FIRST_ANALOG_INPUT_SEL; // RL19
      s_d.cfg.dacSoft = 1'b1; // RL20
      s_d.cfg.dacMix = `CIMS_MIX_OFF; // RL20
      s_d.cfg.dacVol = `CIMS_VOL_0DB; // RL20
      s_d.cfg.out1Src = `CIMS_SRC_DAC1; // RL20
      s_d.cfg.out2Src = `CIMS_SRC_DAC2; // RL20
      s_d.cfg.out3Src = `CIMS_SRC_FIRST_ANALOG_INPUT; // RL20
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      s_q <= '0; // RL5
    end else begin
      s_q <= s_d;
    end
  end

  assign link.externalMuteControl_n = s_q.muteN; // RL4
  assign link.sdoOut = s_q.sdoOut;
  assign link.sdoOe = s_q.sdoOe;
  assign link.faultOut = 1'b0;
  assign link.faultOe = s_q.cfg.faultEn && s_q.ratioFault; // RL17
  assign dacData = s_q.dacData;
  assign dacEnable = s_q.dacEnable;
  assign hwMode = s_q.hwMode;
  assign modeValid = s_q.modeValid;
  assign clockRatio = s_q.ratio;
  assign ratioFault = s_q.ratioFault;
  assign seqState = s_q.state;
  assign hwConfig = s_q.cfg;

endmodule // cims_device

// [core/cims_consts.svh]
/*
  offsets, field positions, reset values and timing counts of the codec init mode sequencer.
  assumes a 125 MHz ref_clk; definitions only.
*/
`ifndef CIMS_CONSTS_SVH
`define CIMS_CONSTS_SVH

`define CIMS_CLK_KHZ 125000
`define CIMS_RAMP_TIME_MS 200
`define CIMS_RAMP_CYCLES (`CIMS_RAMP_TIME_MS * `CIMS_CLK_KHZ)
`define CIMS_MUTE_TIME_US 8
`define CIMS_MUTE_CYCLES ((`CIMS_MUTE_TIME_US * `CIMS_CLK_KHZ) / 1000)
`define CIMS_DAC_START_FRAMES 200
`define CIMS_ZERO_FRAMES 10
`define CIMS_RATIO_128 12'h080
`define CIMS_RATIO_256 12'h100
`define CIMS_RATIO_512 12'h200
`define CIMS_MCLK_HALF 2
`define CIMS_VOL_0DB 8'h00
`define CIMS_SRC_DAC1 3'h1
`define CIMS_SRC_DAC2 3'h2
`define CIMS_SRC_FIRST_ANALOG_INPUT 3'h3
`define CIMS_FIRST_ANALOG_INPUT_SEL 3'h0
`define CIMS_MIX_OFF 2'h0

`define CIMS_REG_CTRL 4'h0
`define CIMS_REG_RATIO 4'h4
`define CIMS_REG_DATA 4'h8
`define CIMS_REG_STATUS 4'hC
`define CIMS_CTRL_RESET 8'h00
`define CIMS_CTRL_REL 0
`define CIMS_CTRL_HWSTRAP 1
`define CIMS_CTRL_PDN 2
`define CIMS_CTRL_MCLK 3
`define CIMS_CTRL_AUDIO 4
`define CIMS_CTRL_MUTE 5
`define CIMS_CTRL_ZERO 6
`define CIMS_RATIO_RESET 2'h1
`define CIMS_DATA_RESET 16'h0000

`endif

// [core/cims_pkg.sv]
/*
  types of the codec init mode sequencer.
  assumes cims_consts.svh for all figures.
*/
package cims_pkg;

  typedef enum logic [2:0] {
    ST_POWERDOWN,
    ST_STANDBY,
    ST_WAIT_MCLK,
    ST_RAMP,
    ST_DETECT,
    ST_RUN,
    ST_MUTING
  } cims_state_t;

  typedef struct packed {
    logic adcPwr;
    logic dac1Pwr;
    logic dac2Pwr;
    logic faultEn;
    logic autoDetect;
    logic syncOnly;
    logic roleLo;
    logic roleHi;
    logic clkDiv;
    logic formatSp1;
    logic formatSp2;
    logic adcSoft;
    logic adcZc;
    logic adcMute;
    logic adcInv;
    logic [7:0] adcVol;
    logic hpfOn;
    logic hpfFreeze;
    logic [2:0] ainSel;
    logic dacSoft;
    logic dacZc;
    logic dacMute;
    logic dacInv;
    logic [1:0] dacMix;
    logic [7:0] dacVol;
    logic deemph;
    logic [2:0] out1Src;
    logic [2:0] out2Src;
    logic [2:0] out3Src;
    logic outMute;
  } cims_cfg_t;

endpackage

// [core/cims_link_if.sv]
/*
  pins between the codec sequencer and its host controller.
  assumes a pull-down on the serial output pin when nobody drives it.
*/
`timescale 1ns/1ps
interface cims_link_if;
  logic chipReset_n;
  logic masterClockOne;
  logic frameClock;
  logic serialAudioInput;
  logic powerDownBit;
  logic softMute;
  logic [4:0] straps;
  logic sdoOut;
  logic sdoOe;
  logic strapOut;
  logic strapOe;
  logic serialAudioOutput;
  logic externalMuteControl_n;
  logic faultOut;
  logic faultOe;
  logic portFaultFlag_n;

  // device driver wins over the host strap pull
  assign serialAudioOutput = sdoOe ? sdoOut : (strapOe ? strapOut : 1'b0);
  // open-drain with pull-up
  assign portFaultFlag_n = faultOe ? faultOut : 1'b1;

  modport device (
    input chipReset_n, masterClockOne, frameClock, serialAudioInput, powerDownBit, softMute, straps,
    input serialAudioOutput,
    output sdoOut, sdoOe, externalMuteControl_n, faultOut, faultOe
  );
  modport host (
    output chipReset_n, masterClockOne, frameClock, serialAudioInput, powerDownBit, softMute, straps,
    output strapOut, strapOe,
    input serialAudioOutput, externalMuteControl_n, portFaultFlag_n
  );
endinterface

// [core/cims_host.sv]
/*
  host controller end: classic wishbone slave registers driving the codec pins.
  assumes the device end on the link; ref_clk at 125 MHz.
*/
`timescale 1ns/1ps
`include "cims_consts.svh"
module cims_host (
  input wire logic ref_clk,
  input wire logic arst_n,
  cims_link_if.host link,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o
);

  typedef struct packed {
    logic [7:0] ctrl;
    logic [4:0] straps;
    logic [1:0] ratioCur;
    logic [1:0] ratioPend;
    logic pending;
    logic [3:0] zeroCnt;
    logic [15:0] data;
    logic [15:0] shift;
    logic rstPin;
    logic [1:0] mclkDiv;
    logic mclk;
    logic [11:0] frmCnt;
    logic frm;
    logic serial_audio_input;
    logic ack;
    logic [31:0] rdat;
    logic [1:0] muteSync;
    logic [1:0] faultSync;
  } cims_host_t;

  cims_host_t s_q;
  cims_host_t s_d;
  logic forceZero;
  logic frmEdge;
  logic [11:0] framePeriod;
  logic wbReq;
  logic wbWr;

  always_comb begin
    case (s_q.ratioCur)
      2'h0: framePeriod = 12'(`CIMS_RATIO_128 * 2 * `CIMS_MCLK_HALF);
      2'h2: framePeriod = 12'(`CIMS_RATIO_512 * 2 * `CIMS_MCLK_HALF);
      default: framePeriod = 12'(`CIMS_RATIO_256 * 2 * `CIMS_MCLK_HALF);
    endcase
  end

  assign forceZero = s_q.pending || !s_q.ctrl[`CIMS_CTRL_REL] || s_q.ctrl[`CIMS_CTRL_ZERO]; // RL1
  assign frmEdge = s_q.ctrl[`CIMS_CTRL_AUDIO] && (s_q.frmCnt == 12'h000);
  assign wbReq = wb_cyc_i && wb_stb_i && !s_q.ack;
  // writes land on the edge that sees ack high
  assign wbWr = wb_cyc_i && wb_stb_i && wb_we_i && s_q.ack;

  always_comb begin
    s_d = s_q;
    s_d.muteSync = {s_q.muteSync[0], link.externalMuteControl_n};
    s_d.faultSync = {s_q.faultSync[0], link.portFaultFlag_n};
    s_d.ack = wbReq;
    if (s_q.ctrl[`CIMS_CTRL_MCLK]) begin
      s_d.mclkDiv = s_q.mclkDiv + 2'h1;
      if (s_q.mclkDiv == 2'(`CIMS_MCLK_HALF - 1)) begin
        s_d.mclkDiv = '0;
        s_d.mclk = !s_q.mclk;
      end
    end else begin
      s_d.mclk = 1'b0;
    end
    // frame clocks and audio only once allowed
    if (s_q.ctrl[`CIMS_CTRL_AUDIO] && s_q.ctrl[`CIMS_CTRL_MCLK]) begin // RL13
      s_d.frmCnt = (s_q.frmCnt >= framePeriod - 12'h001) ? 12'h000 : s_q.frmCnt + 12'h001;
      s_d.frm = s_q.frmCnt < (framePeriod >> 1);
      if (frmEdge) begin
        s_d.shift = s_q.data;
      end else if (s_q.mclkDiv == 2'h0 && s_q.mclk) begin
        s_d.shift = {s_q.shift[14:0], 1'b0};
      end
    end else begin
      s_d.frmCnt = '0;
      s_d.frm = 1'b0;
    end
    s_d.serial_audio_input = !forceZero && s_q.shift[15]; // RL1
    if (!forceZero) begin
      s_d.zeroCnt = '0;
    end else if (frmEdge && s_q.zeroCnt != 4'(`CIMS_ZERO_FRAMES)) begin
      s_d.zeroCnt = s_q.zeroCnt + 4'h1;
    end
    // drained: ten zero frames, or no frames at all
    if (s_q.zeroCnt == 4'(`CIMS_ZERO_FRAMES) || !s_q.ctrl[`CIMS_CTRL_AUDIO]) begin
      if (s_q.pending) begin
        s_d.ratioCur = s_q.ratioPend; // RL1
        s_d.pending = 1'b0;
      end
      if (!s_q.ctrl[`CIMS_CTRL_REL]) begin
        s_d.rstPin = 1'b0; // RL15
      end
    end
    if (s_q.ctrl[`CIMS_CTRL_REL]) begin
      s_d.rstPin = 1'b1; // RL13
    end
    s_d.rdat = '0;
    if (wbReq || wbWr) begin
      if (wb_adr_i == `CIMS_REG_CTRL) begin
        s_d.rdat = {19'h00000, s_q.straps, s_q.ctrl};
        if (wbWr && wb_sel_i[0]) begin
          s_d.ctrl = wb_dat_i[7:0]; // RL14
        end
        if (wbWr && wb_sel_i[1]) begin
          s_d.straps = wb_dat_i[12:8];
        end
      end else if (wb_adr_i == `CIMS_REG_RATIO) begin
        s_d.rdat = {28'h0000000, s_q.ratioPend, s_q.ratioCur};
        if (wbWr && wb_sel_i[0]) begin
          s_d.ratioPend = wb_dat_i[1:0];
          s_d.pending = 1'b1; // RL1
        end
      end else if (wb_adr_i == `CIMS_REG_DATA) begin
        s_d.rdat = {16'h0000, s_q.data};
        if (wbWr && wb_sel_i[0]) begin
          s_d.data[7:0] = wb_dat_i[7:0];
        end
        if (wbWr && wb_sel_i[1]) begin
          s_d.data[15:8] = wb_dat_i[15:8];
        end
      end else if (wb_adr_i == `CIMS_REG_STATUS) begin
        s_d.rdat = {28'h0000000, s_q.rstPin, s_q.pending, s_q.faultSync[1], s_q.muteSync[1]}; // RL14
      end
    end
    if (!wbReq) begin
      s_d.rdat = '0;
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      s_q <= '0;
      s_q.ctrl <= `CIMS_CTRL_RESET;
      s_q.ratioCur <= `CIMS_RATIO_RESET;
      s_q.ratioPend <= `CIMS_RATIO_RESET;
      s_q.data <= `CIMS_DATA_RESET;
    end else begin
      s_q <= s_d;
    end
  end

  assign link.chipReset_n = s_q.rstPin; // RL16
  assign link.masterClockOne = s_q.mclk;
  assign link.frameClock = s_q.frm;
  assign link.serialAudioInput = s_q.serial_audio_input;
  assign link.powerDownBit = s_q.ctrl[`CIMS_CTRL_PDN];
  assign link.softMute = s_q.ctrl[`CIMS_CTRL_MUTE];
  assign link.straps = s_q.straps;
  assign link.strapOut = 1'b1;
  assign link.strapOe = s_q.ctrl[`CIMS_CTRL_HWSTRAP];
  assign wb_ack_o = s_q.ack;
  assign wb_dat_o = s_q.rdat;

endmodule // cims_host

// [verif/cims_link_monitor.sv]
/*
  concurrent checks on the codec link pins between host and device ends.
  assumes the cims_link_if signals and a single ref_clk domain with arst_n.
*/
`timescale 1ns/1ps
`include "cims_consts.svh"
module cims_link_monitor #(
  parameter int DAC_FRAMES = `CIMS_DAC_START_FRAMES
) (
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire logic chipReset_n,
  input wire logic masterClockOne,
  input wire logic frameClock,
  input wire logic powerDownBit,
  input wire logic softMute,
  input wire logic sdoOut,
  input wire logic sdoOe,
  input wire logic externalMuteControl_n
);
  logic [15:0] frameCnt_q;
  logic [3:0] mclkIdle_q;
  logic frameDly_q;
  logic mclkDly_q;

  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!arst_n);

  // frames since chip reset release, and cycles since last master clock edge
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      frameCnt_q <= 16'h0000;
      mclkIdle_q <= 4'h0;
      frameDly_q <= 1'h0;
      mclkDly_q <= 1'h0;
    end else begin
      frameDly_q <= frameClock;
      mclkDly_q <= masterClockOne;
      if (!chipReset_n) begin
        frameCnt_q <= 16'h0000;
      end else if (frameClock && !frameDly_q && frameCnt_q != 16'hFFFF) begin
        frameCnt_q <= frameCnt_q + 16'h0001;
      end
      if (masterClockOne != mclkDly_q) begin
        mclkIdle_q <= 4'h0;
      end else if (mclkIdle_q != 4'hF) begin
        mclkIdle_q <= mclkIdle_q + 4'h1;
      end
    end
  end

  a_reset_mutes: assert property ((!chipReset_n) [*4] |-> !externalMuteControl_n)
    else $error("mute pin high during chip reset");
  a_reset_sdo_free: assert property ((!chipReset_n) [*4] |-> !sdoOe)
    else $error("serial output driven during chip reset");
  a_soft_mutes: assert property (softMute [*4] |-> !externalMuteControl_n)
    else $error("mute pin high while soft mute set");
  a_pdn_mutes: assert property (powerDownBit [*4] |-> !externalMuteControl_n)
    else $error("mute pin high while power-down bit set");
  a_unmute_frames: assert property ($rose(externalMuteControl_n) |-> frameCnt_q >= DAC_FRAMES)
    else $error("unmute before enough frames");
  a_sdo_quiet_ramp: assert property (sdoOe && sdoOut |-> frameCnt_q >= DAC_FRAMES)
    else $error("serial output carries data during ramp");
  a_unmute_cause: assert property ($rose(externalMuteControl_n) |->
    $past(chipReset_n, 3) && !$past(softMute, 3) && !$past(powerDownBit, 3))
    else $error("unmute without its conditions");
  a_mclk_live: assert property ($rose(externalMuteControl_n) |-> mclkIdle_q < 4'h8)
    else $error("unmute without master clock");

  c_unmute: cover property ($rose(externalMuteControl_n));
  c_chip_reset: cover property ($fell(chipReset_n));
  c_pdn_held: cover property (chipReset_n && powerDownBit);
endmodule // cims_link_monitor

// [verif/testbench.sv]
/*
  self-checking bench: host and device ends joined over the link, driven through wishbone.
  assumes the core/ files compiled first and ref_clk at 125 MHz.
*/
`timescale 1ns/1ps
`include "cims_consts.svh"
module testbench;
  localparam logic [4:0] STRAPS = 5'h0D;
  localparam int DAC_FRAMES = 40;
  logic ref_clk;
  logic arst_n;
  logic wbCyc;
  logic wbStb;
  logic wbWe;
  logic [3:0] wbAdr;
  logic [3:0] wbSel;
  logic [31:0] wbDat;
  logic [31:0] wbDatO;
  logic wbAck;
  logic adcBit;
  logic dacData;
  logic dacEnable;
  logic hwMode;
  logic modeValid;
  logic [11:0] clockRatio;
  logic ratioFault;
  cims_pkg::cims_state_t seqState;
  cims_pkg::cims_cfg_t hwConfig;
  logic [31:0] rdData;
  int errorCnt;
  int checkCount;

  cims_link_if cims_link_if_i ();
  cims_device #(.RAMP_CYCLES(50), .MUTE_CYCLES(8), .DAC_FRAMES(DAC_FRAMES)) cims_device_i (.ref_clk(ref_clk),
    .arst_n(arst_n),
    .link(cims_link_if_i), .adcBit(adcBit), .dacData(dacData), .dacEnable(dacEnable), .hwMode(hwMode),
    .modeValid(modeValid), .clockRatio(clockRatio), .ratioFault(ratioFault), .seqState(seqState),
    .hwConfig(hwConfig));
  cims_host cims_host_i (.ref_clk(ref_clk), .arst_n(arst_n), .link(cims_link_if_i), .wb_cyc_i(wbCyc),
    .wb_stb_i(wbStb), .wb_we_i(wbWe), .wb_adr_i(wbAdr), .wb_sel_i(wbSel), .wb_dat_i(wbDat),
    .wb_dat_o(wbDatO), .wb_ack_o(wbAck));
  cims_link_monitor #(.DAC_FRAMES(DAC_FRAMES)) cims_link_monitor_i (.ref_clk(ref_clk), .arst_n(arst_n),
    .chipReset_n(cims_link_if_i.chipReset_n), .masterClockOne(cims_link_if_i.masterClockOne),
    .frameClock(cims_link_if_i.frameClock), .powerDownBit(cims_link_if_i.powerDownBit),
    .softMute(cims_link_if_i.softMute), .sdoOut(cims_link_if_i.sdoOut), .sdoOe(cims_link_if_i.sdoOe),
    .externalMuteControl_n(cims_link_if_i.externalMuteControl_n));

  always #4 ref_clk = ~ref_clk;

  always @(posedge ref_clk) begin
    adcBit <= ~adcBit;
  end

  // converter data stays zero unless audio is enabled
  always @(negedge ref_clk) begin
    if (arst_n && dacData === 1'h1 && dacEnable !== 1'h1) begin
      errorCnt++;
      $display("CHECK FAILED dacData expected 0 seen 1");
    end
  end

  task automatic wrap_up();
    if (errorCnt == 0 && checkCount > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic chk(input string name, input logic [63:0] exp, input logic [63:0] got);
    checkCount++;
    if (got !== exp) begin
      errorCnt++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic wb_access(input logic we, input logic [3:0] adr, input logic [31:0] wdat,
    output logic [31:0] rdat);
    int n;
    @(posedge ref_clk);
    wbCyc <= 1'h1;
    wbStb <= 1'h1;
    wbWe <= we;
    wbSel <= 4'hF;
    wbAdr <= adr;
    wbDat <= wdat;
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
    end while (wbAck !== 1'h1 && n < 50);
    rdat = wbDatO;
    wbCyc <= 1'h0;
    wbStb <= 1'h0;
    wbWe <= 1'h0;
    if (wbAck !== 1'h1) begin
      errorCnt++;
      $display("CHECK FAILED wishbone ack expected 1 seen %b", wbAck);
      wrap_up();
    end
  endtask

  task automatic ctrl(input logic [7:0] bits);
    wb_access(1'h1, `CIMS_REG_CTRL, {19'h0, STRAPS, bits}, rdData);
  endtask

  task automatic reg_chk(input string name, input logic [3:0] adr, input logic [31:0] mask, input logic [31:0] exp);
    wb_access(1'h0, adr, 32'h0, rdData);
    chk(name, exp, rdData & mask);
  endtask

  function automatic logic [63:0] probe(input int kind);
    case (kind)
      0: return 64'(seqState);
      1: return 64'(cims_link_if_i.externalMuteControl_n);
      2: return 64'(dacEnable);
      3: return 64'(modeValid);
      default: return 64'(clockRatio);
    endcase
  endfunction

  task automatic wait_until(input string name, input int kind, input logic [63:0] v, input int lim);
    int n;
    n = 0;
    while (probe(kind) !== v && n < lim) begin
      @(posedge ref_clk);
      n++;
    end
    chk(name, v, probe(kind));
    if (probe(kind) !== v) begin
      wrap_up();
    end
  endtask

  function automatic cims_pkg::cims_cfg_t hw_cfg(input logic [4:0] s);
    return '{1'h1, 1'h1, 1'h1, 1'h1, 1'h1, 1'h1, s[0], s[1], s[2], s[3], s[3], 1'h1, 1'h0, 1'h0, 1'h0,
      `CIMS_VOL_0DB, 1'h1, 1'h0, `CIMS_FIRST_ANALOG_INPUT_SEL, 1'h1, 1'h0, 1'h0, 1'h0, `CIMS_MIX_OFF, `CIMS_VOL_0DB, 1'h0,
      `CIMS_SRC_DAC1, `CIMS_SRC_DAC2, `CIMS_SRC_FIRST_ANALOG_INPUT, s[4]};
  endfunction

  initial begin
    ref_clk = 1'h0;
    arst_n = 1'h0;
    wbCyc = 1'h0;
    wbStb = 1'h0;
    wbWe = 1'h0;
    wbAdr = 4'h0;
    wbSel = 4'hF;
    wbDat = 32'h0;
    adcBit = 1'h0;
    errorCnt = 0;
    checkCount = 0;
    repeat (20) @(posedge ref_clk);
    arst_n <= 1'h1;
    @(posedge ref_clk);
    chk("seqState", cims_pkg::ST_POWERDOWN, seqState);
    chk("mute pin", 1'h0, cims_link_if_i.externalMuteControl_n);
    reg_chk("ctrl", `CIMS_REG_CTRL, 32'hFFFFFFFF, 32'h0);
    reg_chk("ratio", `CIMS_REG_RATIO, 32'h3, 32'(`CIMS_RATIO_RESET));
    reg_chk("data", `CIMS_REG_DATA, 32'hFFFFFFFF, 32'h0);
    reg_chk("unmapped", 4'h2, 32'hFFFFFFFF, 32'h0);
    reg_chk("status", `CIMS_REG_STATUS, 32'h9, 32'h0);
    // software mode: release with the pin low, power-down bit held
    ctrl(8'h0D);
    wait_until("modeValid", 3, 1'h1, 20);
    chk("hwMode", 1'h0, hwMode);
    chk("hwConfig sw", '0, hwConfig);
    repeat (100) @(posedge ref_clk);
    chk("standby", cims_pkg::ST_STANDBY, seqState);
    reg_chk("status", `CIMS_REG_STATUS, 32'h9, 32'h8);
    ctrl(8'h09);
    wait_until("ramp", 0, cims_pkg::ST_RAMP, 40);
    chk("mute in ramp", 1'h0, cims_link_if_i.externalMuteControl_n);
    ctrl(8'h0D);
    wait_until("muting", 0, cims_pkg::ST_MUTING, 20);
    wait_until("back to standby", 0, cims_pkg::ST_STANDBY, 40);
    // hardware mode with strap pull-up
    ctrl(8'h00);
    repeat (10) @(posedge ref_clk);
    chk("powerdown", cims_pkg::ST_POWERDOWN, seqState);
    chk("modeValid low", 1'h0, modeValid);
    ctrl(8'h0B);
    wait_until("modeValid", 3, 1'h1, 20);
    chk("hwMode", 1'h1, hwMode);
    chk("hwConfig hw", hw_cfg(STRAPS), hwConfig);
    ctrl(8'h09);
    repeat (10) @(posedge ref_clk);
    chk("hwMode latched", 1'h1, hwMode);
    wb_access(1'h1, `CIMS_REG_RATIO, 32'h0, rdData);
    wb_access(1'h1, `CIMS_REG_DATA, 32'hA5A5, rdData);
    ctrl(8'h19);
    wait_until("run", 0, cims_pkg::ST_RUN, 3000);
    chk("clockRatio", `CIMS_RATIO_128, clockRatio);
    chk("ratioFault", 1'h0, ratioFault);
    chk("fault pin", 1'h1, cims_link_if_i.portFaultFlag_n);
    chk("mute before start", 1'h0, cims_link_if_i.externalMuteControl_n);
    wait_until("dacEnable", 2, 1'h1, 25000);
    wait_until("unmute", 1, 1'h1, 20);
    ctrl(8'h39);
    wait_until("soft mute", 1, 1'h0, 20);
    ctrl(8'h19);
    wb_access(1'h1, `CIMS_REG_RATIO, 32'h1, rdData);
    wait_until("dacEnable drop", 2, 1'h0, 12000);
    wait_until("new ratio", 4, `CIMS_RATIO_256, 20000);
    // hardware shutdown: quiet the stream, stop frames, then reset
    wb_access(1'h1, `CIMS_REG_DATA, 32'h0, rdData);
    ctrl(8'h0B);
    ctrl(8'h00);
    wait_until("shutdown", 0, cims_pkg::ST_POWERDOWN, 200);
    chk("mute at shutdown", 1'h0, cims_link_if_i.externalMuteControl_n);
    wrap_up();
  end
endmodule // testbench
